//--- hdl/tbk_pkg.sv
// Purpose: constants and types for the timer block clock and interrupt logic
// Assumes: classic wishbone, 32-bit data, word aligned registers
// Notes: offsets are byte addresses
package tbk_pkg;
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_AUX_CTRL = 8'h04;
	localparam logic [7:0] ADR_CORE_CTRL = 8'h08;
	localparam logic [7:0] ADR_AUX_CNT = 8'h0C;
	localparam logic [7:0] ADR_CORE_CNT = 8'h10;
	localparam logic [7:0] ADR_CAP = 8'h14;
	localparam logic [7:0] ADR_STAT = 8'h18;
	localparam logic [7:0] ADR_MASK = 8'h1C;
	localparam logic [1:0] BPS_DIV2 = 2'h1;
	localparam logic [1:0] BPS_DIV4 = 2'h0;
	localparam logic [1:0] BPS_DIV8 = 2'h3;
	localparam logic [1:0] BPS_DIV16 = 2'h2;
	localparam logic [1:0] BPS_RESET = 2'h0;
	localparam logic [1:0] CES_NONE = 2'h0;
	localparam logic [1:0] CES_RISE = 2'h1;
	localparam logic [1:0] CES_FALL = 2'h2;
	localparam logic [1:0] CES_ANY = 2'h3;
	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_COUNTER = 2'h1;
	localparam logic [1:0] MODE_GATE_LO = 2'h2;
	localparam logic [1:0] MODE_GATE_HI = 2'h3;
	localparam int IRQ_AUX = 0;
	localparam int IRQ_CORE = 1;
	localparam int IRQ_CAP = 2;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	// timer control word layout: run, down, mode, prescale
	typedef struct packed {
		logic run;
		logic down;
		logic [1:0] mode;
		logic [2:0] prescale;
	} tbk_tctl_s;
	typedef struct packed {
		logic count_in;
		logic gate_in;
	} tbk_pins_s;
endpackage

//--- hdl/tbk_top.sv
// Purpose: basic clock prescaler, input sampling, two timers, capture and irq
// Assumes: one 100 MHz clock, external pins asynchronous
// Notes: interrupt status bits clear on read of the status register
//
// The address map and the Wishbone register port were chosen for this implementation.
module tbk_top (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire tbk_pkg::tbk_pins_s aux_pins_in,
	input wire tbk_pkg::tbk_pins_s core_pins_in,
	input wire logic capture_pin_in,
	output logic irq_out
);
	logic [1:0] block_prescale_sel_ff;
	logic [1:0] capture_edge_sel_ff;
	logic cap_enable_ff;
	tbk_pkg::tbk_tctl_s tctl_ff [2];
	logic [15:0] cnt_ff [2];
	logic [15:0] capture_reload_reg_ff;
	logic [2:0] stat_ff;
	logic [2:0] mask_ff;
	logic wb_ack_ff;
	logic [31:0] rdata_ff;
	logic [3:0] bdiv_ff;
	logic [10:0] pdiv_ff;
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] samp_ff;
	logic [4:0] samp_old_ff;
	logic base_en_ff;

	wire logic wb_req = wb_cyc_in && wb_stb_in && !wb_ack_ff;
	wire logic wb_wr = wb_req && wb_we_in && wb_sel_in[0];
	wire logic wb_rd = wb_req && !wb_we_in;
	wire logic [4:0] pins_raw = {capture_pin_in, core_pins_in, aux_pins_in};

	function automatic logic [3:0] div_mask(input logic [1:0] sel);
		unique case (sel)
			tbk_pkg::BPS_DIV2: div_mask = 4'h1;
			tbk_pkg::BPS_DIV4: div_mask = 4'h3;
			tbk_pkg::BPS_DIV8: div_mask = 4'h7;
			tbk_pkg::BPS_DIV16: div_mask = 4'hF;
		endcase
	endfunction

	wire logic base_tick = (bdiv_ff & div_mask(block_prescale_sel_ff)) == 4'h0;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bdiv_ff <= 4'h0;
			base_en_ff <= 1'b0;
		end else begin
			bdiv_ff <= bdiv_ff + 4'h1;
			base_en_ff <= base_tick;
		end
	end

	// shared power-of-two prescaler on basic clock
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pdiv_ff <= 11'h000;
		end else if (base_en_ff) begin
			pdiv_ff <= pdiv_ff + 11'h001;
		end
	end

	// two stage synchroniser on module clock
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync1_ff <= 5'h00;
			sync2_ff <= 5'h00;
		end else begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
		end
	end

	// sample on basic clock; keep previous sample
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			samp_ff <= 5'h00;
			samp_old_ff <= 5'h00;
		end else if (base_en_ff) begin
			samp_ff <= sync2_ff;
			samp_old_ff <= samp_ff;
		end
	end

	wire logic [4:0] edge_any = (samp_ff ^ samp_old_ff) & {5{base_en_ff}};
	wire logic cap_rise = edge_any[4] && samp_ff[4];
	wire logic cap_fall = edge_any[4] && !samp_ff[4];
	wire logic cap_evt = cap_enable_ff && (
		(capture_edge_sel_ff == tbk_pkg::CES_RISE && cap_rise) ||
		(capture_edge_sel_ff == tbk_pkg::CES_FALL && cap_fall) ||
		(capture_edge_sel_ff == tbk_pkg::CES_ANY && edge_any[4]));

	logic [1:0] wrap_evt;
	logic [1:0] step;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_tmr
			wire logic cnt_pin = samp_ff[2 * g + 1];
			wire logic gate_pin = samp_ff[2 * g];
			wire logic [2:0] ps = tctl_ff[g].prescale;
			wire logic [10:0] pmask = 11'((12'h001 << ps) - 12'h001);
			wire logic ptick = base_en_ff && ((pdiv_ff & pmask) == 11'h000);
			wire logic gate_ok = (tctl_ff[g].mode == tbk_pkg::MODE_GATE_HI) ? gate_pin :
				(tctl_ff[g].mode == tbk_pkg::MODE_GATE_LO) ? !gate_pin : 1'b1;
			// internal count; counter mode counts pin edges
			assign step[g] = tctl_ff[g].run && ((tctl_ff[g].mode == tbk_pkg::MODE_COUNTER) ?
				edge_any[2 * g + 1] : (ptick && gate_ok));
			assign wrap_evt[g] = step[g] && (tctl_ff[g].down ?
				(cnt_ff[g] == tbk_pkg::CNT_ZERO) : (cnt_ff[g] == tbk_pkg::CNT_MAX));
			wire logic [7:0] wadr = (g == 0) ? tbk_pkg::ADR_AUX_CNT : tbk_pkg::ADR_CORE_CNT;
			wire logic [7:0] cadr = (g == 0) ? tbk_pkg::ADR_AUX_CTRL : tbk_pkg::ADR_CORE_CTRL;
			wire logic [15:0] nxt_cnt = tctl_ff[g].down ? cnt_ff[g] - 16'h0001 :
				cnt_ff[g] + 16'h0001;
			always_ff @(posedge clock_in or negedge rstn_in) begin
				if (!rstn_in) begin
					cnt_ff[g] <= 16'h0000;
					tctl_ff[g] <= '0;
				end else begin
					if (wb_wr && wb_adr_in == wadr) begin
						cnt_ff[g] <= wb_dat_in[15:0];
					end else if (step[g]) begin
						cnt_ff[g] <= nxt_cnt;
					end
					if (wb_wr && wb_adr_in == cadr) begin
						tctl_ff[g] <= wb_dat_in[6:0];
					end
				end
			end
		end
	endgenerate

	// capture latches aux timer
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			capture_reload_reg_ff <= 16'h0000;
		end else if (cap_evt) begin
			capture_reload_reg_ff <= cnt_ff[0];
		end else if (wb_wr && wb_adr_in == tbk_pkg::ADR_CAP) begin
			capture_reload_reg_ff <= wb_dat_in[15:0];
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			block_prescale_sel_ff <= tbk_pkg::BPS_RESET;
			capture_edge_sel_ff <= tbk_pkg::CES_NONE;
			cap_enable_ff <= 1'b0;
			mask_ff <= 3'h0;
		end else if (wb_wr) begin
			if (wb_adr_in == tbk_pkg::ADR_CTRL) begin
				block_prescale_sel_ff <= wb_dat_in[1:0];
				capture_edge_sel_ff <= wb_dat_in[3:2];
				cap_enable_ff <= wb_dat_in[4];
			end
			if (wb_adr_in == tbk_pkg::ADR_MASK) begin
				mask_ff <= wb_dat_in[2:0];
			end
		end
	end

	// three identical status bits; set wins over read clear
	wire logic [2:0] evt = {cap_evt, wrap_evt[1], wrap_evt[0]};
	wire logic stat_rd = wb_rd && wb_adr_in == tbk_pkg::ADR_STAT;
	wire logic [2:0] nxt_stat = (stat_rd ? 3'h0 : stat_ff) | evt;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stat_ff <= 3'h0;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	assign irq_out = |(stat_ff & mask_ff);

	wire logic [31:0] rd_mux =
		(wb_adr_in == tbk_pkg::ADR_CTRL) ? {27'h0, cap_enable_ff, capture_edge_sel_ff,
			block_prescale_sel_ff} :
		(wb_adr_in == tbk_pkg::ADR_AUX_CTRL) ? {25'h0, tctl_ff[0]} :
		(wb_adr_in == tbk_pkg::ADR_CORE_CTRL) ? {25'h0, tctl_ff[1]} :
		(wb_adr_in == tbk_pkg::ADR_AUX_CNT) ? {16'h0, cnt_ff[0]} :
		(wb_adr_in == tbk_pkg::ADR_CORE_CNT) ? {16'h0, cnt_ff[1]} :
		(wb_adr_in == tbk_pkg::ADR_CAP) ? {16'h0, capture_reload_reg_ff} :
		(wb_adr_in == tbk_pkg::ADR_STAT) ? {29'h0, stat_ff} :
		(wb_adr_in == tbk_pkg::ADR_MASK) ? {29'h0, mask_ff} : 32'h0000_0000;

	// one wait state slave
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wb_ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			wb_ack_ff <= wb_req;
			rdata_ff <= wb_rd ? rd_mux : 32'h0000_0000;
		end
	end
	assign wb_ack_out = wb_ack_ff;
	assign wb_dat_out = rdata_ff;

	// assertion helpers
	logic [4:0] gap_ff;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			gap_ff <= 5'h00;
		end else begin
			gap_ff <= base_en_ff ? 5'h00 : gap_ff + 5'h01;
		end
	end

	// spacing only judged while the prescale field held since the last tick
	logic spc_ok_ff;
	wire logic bps_wr = wb_wr && wb_adr_in == tbk_pkg::ADR_CTRL;
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			spc_ok_ff <= 1'b0;
		end else if (bps_wr && wb_dat_in[1:0] != block_prescale_sel_ff) begin
			spc_ok_ff <= 1'b0;
		end else if (base_en_ff) begin
			spc_ok_ff <= 1'b1;
		end
	end

	sequence s_up_at_max(int i);
		wrap_evt[i] && !tctl_ff[i].down &&
			!(wb_wr && wb_adr_in == ((i == 0) ? tbk_pkg::ADR_AUX_CNT : tbk_pkg::ADR_CORE_CNT));
	endsequence
	sequence s_wb_taken;
		wb_req;
	endsequence
	sequence s_ack_once;
		wb_ack_out ##1 !wb_ack_out;
	endsequence

	chk_base_spacing: assert property (@(posedge clock_in) disable iff (!rstn_in)
		base_en_ff && spc_ok_ff |-> gap_ff == 5'(div_mask(block_prescale_sel_ff)))
		else $error("basic clock spacing wrong");
	chk_reset_div: assert property (@(posedge clock_in) disable iff (!rstn_in)
		$rose(rstn_in) |-> block_prescale_sel_ff == tbk_pkg::BPS_DIV4)
		else $error("prescale not default");
	chk_sample_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!base_en_ff |=> $stable(samp_ff))
		else $error("sample changed off basic tick");
	chk_edge_diff: assert property (@(posedge clock_in) disable iff (!rstn_in)
		edge_any[4] |-> samp_ff[4] != samp_old_ff[4])
		else $error("edge without level change");
	chk_up_wrap: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_up_at_max(1) |=> stat_ff[1] && cnt_ff[1] == tbk_pkg::CNT_ZERO)
		else $error("up wrap flag missing");
	chk_down_wrap: assert property (@(posedge clock_in) disable iff (!rstn_in)
		wrap_evt[0] && tctl_ff[0].down && !(wb_wr && wb_adr_in == tbk_pkg::ADR_AUX_CNT)
			|=> stat_ff[0] && cnt_ff[0] == tbk_pkg::CNT_MAX)
		else $error("down wrap flag missing");
	chk_irq_level: assert property (@(posedge clock_in) disable iff (!rstn_in)
		evt[2] && mask_ff[2] && !(wb_wr && wb_adr_in == tbk_pkg::ADR_MASK) |=> irq_out)
		else $error("irq not raised");
	chk_cap_flag: assert property (@(posedge clock_in) disable iff (!rstn_in)
		cap_evt |=> stat_ff[2] && capture_reload_reg_ff == $past(cnt_ff[0]))
		else $error("capture flag or value wrong");
	chk_fall_only: assert property (@(posedge clock_in) disable iff (!rstn_in)
		cap_evt && capture_edge_sel_ff == tbk_pkg::CES_FALL |-> !samp_ff[4])
		else $error("falling select took rising edge");
	chk_sync_delay: assert property (@(posedge clock_in) disable iff (!rstn_in)
		sync2_ff == $past(pins_raw, 2) || $past(rstn_in, 2) == 1'b0)
		else $error("sync depth wrong");
	chk_ack_after: assert property (@(posedge clock_in) disable iff (!rstn_in)
		s_wb_taken |=> s_ack_once)
		else $error("ack not one cycle after request");
	chk_ack_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
		wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	chk_rdata_idle: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
		else $error("read data outside ack");
	chk_stat_clear: assert property (@(posedge clock_in) disable iff (!rstn_in)
		stat_rd && evt == 3'h0 |=> stat_ff == 3'h0)
		else $error("status not cleared by read");
	chk_stat_sticky: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!stat_rd |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
		else $error("status bit lost without read");
	chk_rise_only: assert property (@(posedge clock_in) disable iff (!rstn_in)
		cap_evt && capture_edge_sel_ff == tbk_pkg::CES_RISE |-> samp_ff[4])
		else $error("rising select took falling edge");
	chk_none_sel: assert property (@(posedge clock_in) disable iff (!rstn_in)
		capture_edge_sel_ff == tbk_pkg::CES_NONE |-> !cap_evt)
		else $error("capture with no edge selected");
	chk_cap_gate: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!cap_enable_ff |-> !cap_evt)
		else $error("capture while disabled");
	chk_count_pin: assert property (@(posedge clock_in) disable iff (!rstn_in)
		tctl_ff[0].run && tctl_ff[0].mode == tbk_pkg::MODE_COUNTER && edge_any[1] &&
			!(wb_wr && wb_adr_in == tbk_pkg::ADR_AUX_CNT) |=> cnt_ff[0] != $past(cnt_ff[0]))
		else $error("count pin edge not counted");
	chk_step_tick: assert property (@(posedge clock_in) disable iff (!rstn_in)
		step != 2'h0 |-> base_en_ff)
		else $error("count step off basic tick");
	chk_edge_tick: assert property (@(posedge clock_in) disable iff (!rstn_in)
		edge_any != 5'h00 |-> base_en_ff)
		else $error("edge seen off basic tick");
	chk_stop_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!tctl_ff[0].run && !(wb_wr && wb_adr_in == tbk_pkg::ADR_AUX_CNT) |=> $stable(cnt_ff[0]))
		else $error("stopped timer moved");
	chk_pdiv_hold: assert property (@(posedge clock_in) disable iff (!rstn_in)
		!base_en_ff |=> $stable(pdiv_ff))
		else $error("input prescaler moved off tick");
	chk_bdiv_run: assert property (@(posedge clock_in) disable iff (!rstn_in)
		1'b1 |=> bdiv_ff == 4'($past(bdiv_ff) + 4'h1))
		else $error("block prescaler not counting");
	chk_bps_write: assert property (@(posedge clock_in) disable iff (!rstn_in)
		bps_wr |=> block_prescale_sel_ff == $past(wb_dat_in[1:0]))
		else $error("prescale field write lost");
	chk_gate_block: assert property (@(posedge clock_in) disable iff (!rstn_in)
		tctl_ff[0].mode == tbk_pkg::MODE_GATE_LO && samp_ff[0] |-> !step[0])
		else $error("closed gate let timer count");
endmodule

//--- testbench/tbk_pin_src.sv
// Purpose: pin source model for the timer block count, gate and capture inputs
// Assumes: one level flip per step request, gates held high
// Notes: a flip waits until the current level has stood hold_in clocks
module tbk_pin_src (
	input wire logic clock_in,
	input wire logic step_in,
	input wire logic [4:0] hold_in,
	output tbk_pkg::tbk_pins_s aux_out,
	output tbk_pkg::tbk_pins_s core_out,
	output logic cap_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic lvl_ff = 1'b0;
	logic pend_ff = 1'b0;
	logic [4:0] cnt_ff = 5'h00;
	assign aux_out = '{count_in: lvl_ff, gate_in: 1'b1};
	assign core_out = '{count_in: lvl_ff, gate_in: 1'b1};
	assign cap_out = lvl_ff;
	always_ff @(posedge clock_in) begin
		cnt_ff <= (cnt_ff == 5'h1f) ? cnt_ff : cnt_ff + 5'h01;
		if (step_in) begin
			pend_ff <= 1'b1;
		end
		if ((pend_ff || step_in) && cnt_ff >= hold_in) begin
			lvl_ff <= !lvl_ff;
			pend_ff <= 1'b0;
			cnt_ff <= 5'h00;
		end
	end
endmodule

//--- testbench/tbk_top_test.sv
// Purpose: self-checking bench for the timer block clock and irq logic
// Assumes: one ack per request, one cycle after it is taken
// Notes: rates are checked over windows that are whole tick periods
module tbk_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_in = 1'b0;
	logic rstn_in = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000;
	logic [31:0] dout;
	logic [31:0] rd;
	logic [31:0] base;
	logic ack;
	logic irq;
	logic step = 1'b0;
	logic cap_p;
	logic exp_b;
	tbk_pkg::tbk_pins_s aux_p;
	tbk_pkg::tbk_pins_s core_p;
	logic [1:0] bps [4] = '{tbk_pkg::BPS_DIV2, tbk_pkg::BPS_DIV4, tbk_pkg::BPS_DIV8,
		tbk_pkg::BPS_DIV16};
	logic [15:0] dv [4] = '{16'h0040, 16'h0020, 16'h0010, 16'h0008};
	int error_cnt = 0;
	int checks = 0;
	`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); end end
	always #5 clock_in = ~clock_in;
	tbk_top dut (.clock_in(clock_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(dout),
		.wb_ack_out(ack), .aux_pins_in(aux_p), .core_pins_in(core_p),
		.capture_pin_in(cap_p), .irq_out(irq));
	tbk_pin_src src (.clock_in(clock_in), .step_in(step), .hold_in(5'h04), .aux_out(aux_p),
		.core_out(core_p), .cap_out(cap_p));
	task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) error_cnt++;
		rd = dout;
		cyc <= 1'b0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		wb(1'b0, a, 4'hf, 32'h0000_0000);
		`CHK(nm, e, rd)
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10000) @(posedge clock_in);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (5) @(posedge clock_in);
		rstn_in <= 1'b1;
		rdc(tbk_pkg::ADR_CTRL, 32'h0000_0000, "ctrl reset");
		wb(1'b1, tbk_pkg::ADR_CTRL, 4'h2, 32'h0000_0001);
		rdc(tbk_pkg::ADR_CTRL, 32'h0000_0000, "ctrl no sel");
		wb(1'b1, 8'h3C, 4'hf, 32'hffff_ffff);
		rdc(8'h3C, 32'h0000_0000, "unmapped");
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, tbk_pkg::ADR_CTRL, 4'h1, {30'h0, bps[i]});
			wb(1'b1, tbk_pkg::ADR_AUX_CTRL, 4'h1, 32'h0000_0041);
			wb(1'b0, tbk_pkg::ADR_AUX_CNT, 4'hf, 32'h0000_0000);
			base = rd;
			repeat (253) @(posedge clock_in);
			wb(1'b0, tbk_pkg::ADR_AUX_CNT, 4'hf, 32'h0000_0000);
			`CHK("aux rate", 16'(base[15:0] + dv[i]), rd[15:0])
		end
		wb(1'b1, tbk_pkg::ADR_CTRL, 4'h1, {30'h0, tbk_pkg::BPS_DIV2});
		wb(1'b1, tbk_pkg::ADR_AUX_CTRL, 4'h1, 32'h0000_0000);
		wb(1'b1, tbk_pkg::ADR_AUX_CNT, 4'hf, 32'h0000_0000);
		wb(1'b1, tbk_pkg::ADR_CORE_CNT, 4'hf, 32'h0000_ffff);
		wb(1'b1, tbk_pkg::ADR_MASK, 4'hf, 32'h0000_0000);
		wb(1'b0, tbk_pkg::ADR_STAT, 4'hf, 32'h0000_0000);
		wb(1'b1, tbk_pkg::ADR_AUX_CTRL, 4'h1, 32'h0000_0060);
		wb(1'b1, tbk_pkg::ADR_CORE_CTRL, 4'h1, 32'h0000_0040);
		repeat (20) @(posedge clock_in);
		wb(1'b1, tbk_pkg::ADR_AUX_CTRL, 4'h1, 32'h0000_0000);
		wb(1'b1, tbk_pkg::ADR_CORE_CTRL, 4'h1, 32'h0000_0000);
		`CHK("irq masked", 1'b0, irq)
		wb(1'b1, tbk_pkg::ADR_MASK, 4'hf, 32'h0000_0007);
		@(posedge clock_in);
		`CHK("irq on", 1'b1, irq)
		rdc(tbk_pkg::ADR_STAT, 32'h0000_0003, "wrap flags");
		`CHK("irq off", 1'b0, irq)
		wb(1'b1, tbk_pkg::ADR_AUX_CNT, 4'hf, 32'h0000_0000);
		wb(1'b1, tbk_pkg::ADR_AUX_CTRL, 4'h1, 32'h0000_0048);
		for (int s = 0; s < 4; s++) begin
			wb(1'b1, tbk_pkg::ADR_CTRL, 4'h1, {27'h0, 1'b1, 2'(s), tbk_pkg::BPS_DIV2});
			wb(1'b0, tbk_pkg::ADR_STAT, 4'hf, 32'h0000_0000);
			for (int e = 0; e < 2; e++) begin
				step <= 1'b1;
				@(posedge clock_in);
				step <= 1'b0;
				repeat (30) @(posedge clock_in);
				exp_b = (s == 3) || (s == 1 && e == 0) || (s == 2 && e == 1);
				`CHK("cap irq", exp_b, irq)
				wb(1'b0, tbk_pkg::ADR_STAT, 4'hf, 32'h0000_0000);
				`CHK("cap flag", exp_b, rd[2])
			end
		end
		rdc(tbk_pkg::ADR_AUX_CNT, 32'h0000_0008, "edge count");
		stop_test();
	end
endmodule
